// ===== hdl/sch_smart_command_handler.sv
`timescale 1ns/1ns
`include "sch_defs.svh"
module sch_smart_command_handler #(
  parameter int HALT_LIMIT_CYC = `HALT_LIMIT_MS * `CLK_KHZ
) (
  input  wire logic            clk_sys,
  input  wire logic            rst_b,
  input  wire logic            ce,
  input  wire logic [3:0]      busAddr,
  input  wire logic [7:0]      busWdata,
  input  wire logic            busWr,
  input  wire logic            busRd,
  output logic      [7:0]      busRdata,
  output logic                 intrq,
  input  wire logic            nvEnableIn,
  input  wire logic            nvAutosaveIn,
  input  wire logic            nvAutoOffIn,
  output logic                 nvWrite,
  output logic                 nvEnable,
  output logic                 nvAutosave,
  output logic                 nvAutoOff,
  output logic                 monitorEn,
  output logic                 mediaReq,
  output sch_pkg::sch_op_t     mediaOp,
  output logic      [7:0]      mediaLogAddr,
  input  wire logic            mediaDone,
  input  wire logic            mediaFail,
  input  wire logic            bufWe,
  input  wire logic [8:0]      bufAddr,
  input  wire logic [7:0]      bufWdata,
  output logic      [7:0]      bufRdata,
  output logic                 routineStart,
  output logic                 routineResume,
  output logic                 routineHalt,
  output logic      [1:0]      routineKind,
  input  wire logic            routineDone
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic scValid(input logic [7:0] sc, input logic [7:0] onCode);
    scValid = (sc == `SC_OFF) || (sc == onCode);
  endfunction

  function automatic logic hostLog(input logic [7:0] a);
    hostLog = (a >= `LOG_HOST_LO) && (a <= `LOG_HOST_HI);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]          featReg;
  logic [7:0]          scntReg;
  logic [7:0]          snumReg;
  logic [7:0]          cylLoReg;
  logic [7:0]          cylHiReg;
  logic [7:0]          rdDataReg;
  logic [7:0]          stestReg;
  logic [8:0]          ptrReg;
  logic                drqReg;
  logic                errStReg;
  logic                abrtReg;
  logic                intrqReg;
  logic                chainReg;
  logic                pendStartReg;
  logic                resumeOkReg;
  logic                enableReg;
  logic                autosaveReg;
  logic                autoOffReg;
  logic                nvLoadReg;
  logic                nvWriteReg;
  logic                routineOnReg;
  logic                suspReg;
  logic                startReg;
  logic                resumeReg;
  logic                haltReg;
  logic [1:0]          kindReg;
  logic [7:0]          sectorMem [0:511];
  sch_pkg::sch_state_t stateReg;
  sch_pkg::sch_op_t    opReg;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire idle       = stateReg == sch_pkg::SCH_IDLE;
  wire hostWr     = ce && busWr;
  wire hostRd     = ce && busRd;
  wire cmdWr      = hostWr && busAddr == `RA_CMD && idle;
  wire isSmart    = busWdata == `CMD_SMART && cylLoReg == `KEY_LO && cylHiReg == `KEY_HI;
  wire isD4       = featReg == `SUB_EXEC;
  wire snOffline  = snumReg <= `SN_EXT_OFF;
  wire snCaptive  = snumReg == `SN_SHORT_CAP || snumReg == `SN_EXT_CAP;
  wire subKnown   = featReg >= `SUB_RDATTR && featReg <= `SUB_AUTOOFF
                    && featReg != `SUB_GAP;
  wire badD2      = featReg == `SUB_AUTOSAVE && !scValid(scntReg, `SC_AUTOSAVE_ON);
  wire badD4      = isD4 && !snOffline && !snCaptive && snumReg != `SN_ABORT;
  wire extLog     = snumReg == `LOG_XERR || snumReg == `LOG_XSTEST;
  wire badD5      = featReg == `SUB_RDLOG && (scntReg != `SC_ONE || extLog);
  wire badD6      = featReg == `SUB_WRLOG && (scntReg != `SC_ONE || !hostLog(snumReg));
  wire badDB      = featReg == `SUB_AUTOOFF && !scValid(scntReg, `SC_AUTOOFF_ON);
  wire offGate    = !enableReg && featReg != `SUB_ENABLE;
  wire abortCmd   = !isSmart || !subKnown || offGate || badD2 || badD4 || badD5 || badD6
                    || badDB;
  wire goCmd      = cmdWr && !abortCmd;
  wire goFeat2    = goCmd && featReg == `SUB_AUTOSAVE;
  wire goFeatB    = goCmd && featReg == `SUB_AUTOOFF;
  wire goEnable   = goCmd && featReg == `SUB_ENABLE && !enableReg;
  wire goDisable  = goCmd && featReg == `SUB_DISABLE;
  wire goOffline  = goCmd && isD4 && snOffline;
  wire goCaptive  = goCmd && isD4 && snCaptive;
  wire mediaHit   = stateReg == sch_pkg::SCH_MEDIA && mediaDone && !chainReg;
  wire checkDone  = ce && mediaHit && opReg == sch_pkg::SCH_OP_CHECK;
  wire stestDone  = ce && mediaHit && opReg == sch_pkg::SCH_OP_SELFTEST;
  wire loadCyl    = checkDone || (stestDone && mediaFail);
  wire xferRd     = hostRd && busAddr == `RA_DATA && stateReg == sch_pkg::SCH_XOUT;
  wire xferWr     = hostWr && busAddr == `RA_DATA && stateReg == sch_pkg::SCH_XIN;
  wire bsyBit     = stateReg == sch_pkg::SCH_MEDIA || stateReg == sch_pkg::SCH_DONE;
  wire statusRd   = hostRd && busAddr == `RA_CMD;
  wire [7:0] statusByte = {bsyBit, !nvLoadReg, 2'b00, drqReg, 2'b00, errStReg};
  wire [7:0] errByte    = {5'b00000, abrtReg, 2'b00};
  wire [7:0] stateByte  = {routineOnReg, suspReg, autoOffReg, autosaveReg, enableReg, 3'b000};
  wire [7:0] rdMux =
    busAddr == `RA_FEAT  ? featReg  :
    busAddr == `RA_SCNT  ? scntReg  :
    busAddr == `RA_SNUM  ? snumReg  :
    busAddr == `RA_CYLO  ? cylLoReg :
    busAddr == `RA_CYHI  ? cylHiReg :
    busAddr == `RA_CMD   ? statusByte :
    busAddr == `RA_ERR   ? errByte  :
    busAddr == `RA_DATA  ? (xferRd ? sectorMem[ptrReg] : 8'h00) :
    busAddr == `RA_STATE ? stestReg :
    busAddr == `RA_MODE  ? stateByte : 8'h00;

  // ----------------------------------------------------------------
  // Task-file registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      featReg  <= 8'h00;
      scntReg  <= 8'h00;
      snumReg  <= 8'h00;
      cylLoReg <= 8'h00;
      cylHiReg <= 8'h00;
    end else if (ce) begin
      if (hostWr && busAddr == `RA_FEAT) featReg <= busWdata;
      if (hostWr && busAddr == `RA_SCNT) scntReg <= busWdata;
      if (hostWr && busAddr == `RA_SNUM) snumReg <= busWdata;
      if (loadCyl) begin
        cylLoReg <= (checkDone && !mediaFail) ? `KEY_LO : `FAIL_LO;
        cylHiReg <= (checkDone && !mediaFail) ? `KEY_HI : `FAIL_HI;
      end else begin
        if (hostWr && busAddr == `RA_CYLO) cylLoReg <= busWdata;
        if (hostWr && busAddr == `RA_CYHI) cylHiReg <= busWdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port and sector buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdDataReg <= 8'h00;
      bufRdata  <= 8'h00;
    end else if (ce) begin
      rdDataReg <= busRd ? rdMux : 8'h00;
      bufRdata  <= sectorMem[bufAddr];
    end
  end

  // The host side wins a same-cycle collision; the media side only writes
  // while the sector is being filled, when no host transfer is open.
  always_ff @(posedge clk_sys) begin
    if (ce) begin
      if (xferWr) begin
        sectorMem[ptrReg] <= busWdata;
      end else if (bufWe) begin
        sectorMem[bufAddr] <= bufWdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      stateReg     <= sch_pkg::SCH_IDLE;
      opReg        <= sch_pkg::SCH_OP_SAVE;
      chainReg     <= 1'b0;
      ptrReg       <= 9'h000;
      drqReg       <= 1'b0;
      errStReg     <= 1'b0;
      abrtReg      <= 1'b0;
      pendStartReg <= 1'b0;
      resumeOkReg  <= 1'b0;
    end else if (ce) begin
      unique case (stateReg)
        sch_pkg::SCH_IDLE: begin
          if (startReg) pendStartReg <= 1'b0;
          if (cmdWr) begin
            errStReg    <= abortCmd;
            abrtReg     <= abortCmd;
            resumeOkReg <= isSmart && !isD4 && featReg != `SUB_DISABLE;
            chainReg    <= 1'b0;
            ptrReg      <= 9'h000;
            stateReg    <= sch_pkg::SCH_DONE;
            if (goOffline) pendStartReg <= 1'b1;
            if (goCmd) begin
              unique case (featReg)
                `SUB_RDATTR: begin
                  opReg    <= sch_pkg::SCH_OP_SAVE;
                  chainReg <= 1'b1;
                  stateReg <= sch_pkg::SCH_MEDIA;
                end
                `SUB_RDTHR: begin
                  opReg    <= sch_pkg::SCH_OP_LOAD_THR;
                  stateReg <= sch_pkg::SCH_MEDIA;
                end
                `SUB_SAVE: begin
                  opReg    <= sch_pkg::SCH_OP_SAVE;
                  stateReg <= sch_pkg::SCH_MEDIA;
                end
                `SUB_EXEC: begin
                  if (snCaptive) begin
                    opReg    <= sch_pkg::SCH_OP_SELFTEST;
                    stateReg <= sch_pkg::SCH_MEDIA;
                  end
                end
                `SUB_RDLOG: begin
                  opReg    <= sch_pkg::SCH_OP_LOAD_LOG;
                  stateReg <= sch_pkg::SCH_MEDIA;
                end
                `SUB_WRLOG: begin
                  drqReg   <= 1'b1;
                  stateReg <= sch_pkg::SCH_XIN;
                end
                `SUB_ENABLE: begin
                  if (!enableReg) begin
                    opReg    <= sch_pkg::SCH_OP_SAVE;
                    stateReg <= sch_pkg::SCH_MEDIA;
                  end
                end
                `SUB_STATUS: begin
                  opReg    <= sch_pkg::SCH_OP_CHECK;
                  stateReg <= sch_pkg::SCH_MEDIA;
                end
                default: begin
                end
              endcase
            end
          end
        end
        sch_pkg::SCH_MEDIA: begin
          if (mediaDone && chainReg) begin
            chainReg <= 1'b0;
            opReg    <= sch_pkg::SCH_OP_LOAD_ATTR;
          end else if (mediaDone) begin
            stateReg <= sch_pkg::SCH_DONE;
            if (opReg == sch_pkg::SCH_OP_SELFTEST && mediaFail) begin
              errStReg <= 1'b1;
              abrtReg  <= 1'b1;
            end
            if (opReg == sch_pkg::SCH_OP_LOAD_ATTR || opReg == sch_pkg::SCH_OP_LOAD_THR
                || opReg == sch_pkg::SCH_OP_LOAD_LOG) begin
              drqReg   <= 1'b1;
              stateReg <= sch_pkg::SCH_XOUT;
            end
          end
        end
        sch_pkg::SCH_XOUT: begin
          if (xferRd) begin
            ptrReg <= ptrReg + 9'h001;
            if (ptrReg == `SECTOR_LAST) begin
              drqReg   <= 1'b0;
              stateReg <= sch_pkg::SCH_DONE;
            end
          end
        end
        sch_pkg::SCH_XIN: begin
          if (xferWr) begin
            ptrReg <= ptrReg + 9'h001;
            if (ptrReg == `SECTOR_LAST) begin
              drqReg   <= 1'b0;
              opReg    <= sch_pkg::SCH_OP_STORE_LOG;
              stateReg <= sch_pkg::SCH_MEDIA;
            end
          end
        end
        sch_pkg::SCH_DONE: stateReg <= sch_pkg::SCH_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request: set wins over the clear from a status read
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      intrqReg <= 1'b0;
    end else if (ce) begin
      intrqReg <= (stateReg == sch_pkg::SCH_DONE) || (intrqReg && !statusRd && !cmdWr);
    end
  end

  // ----------------------------------------------------------------
  // Persistent settings; the stored copy is taken in the first enabled
  // cycle after reset release so a power cycle restores it.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      nvLoadReg   <= 1'b1;
      enableReg   <= 1'b0;
      autosaveReg <= 1'b0;
      autoOffReg  <= 1'b0;
      nvWriteReg  <= 1'b0;
    end else if (ce) begin
      nvWriteReg <= goFeat2 || goFeatB || goEnable || goDisable;
      if (nvLoadReg) begin
        nvLoadReg   <= 1'b0;
        enableReg   <= nvEnableIn;
        autosaveReg <= nvAutosaveIn;
        autoOffReg  <= nvAutoOffIn;
      end else begin
        if (goEnable) enableReg <= 1'b1;
        if (goDisable) begin
          enableReg   <= 1'b0;
          autosaveReg <= 1'b0;
        end
        if (goFeat2) autosaveReg <= scntReg == `SC_AUTOSAVE_ON;
        if (goFeatB) autoOffReg <= scntReg == `SC_AUTOOFF_ON;
      end
    end
  end

  // ----------------------------------------------------------------
  // Off-line routine control. A halt is issued one cycle after any
  // command lands while routineOnReg is set, far inside the allowed window; the routine engine
  // must stop within that window on its own.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      routineOnReg <= 1'b0;
      suspReg      <= 1'b0;
      startReg     <= 1'b0;
      resumeReg    <= 1'b0;
      haltReg      <= 1'b0;
      kindReg      <= 2'b00;
      stestReg     <= 8'h00;
    end else if (ce) begin
      haltReg   <= cmdWr && routineOnReg;
      startReg  <= idle && pendStartReg && !startReg && !cmdWr;
      resumeReg <= 1'b0;
      if (cmdWr && routineOnReg) begin
        routineOnReg <= 1'b0;
        suspReg      <= 1'b1;
      end else if (routineDone) begin
        routineOnReg <= 1'b0;
        if (kindReg != 2'b00) stestReg <= {`STEST_PASS, 4'h0};
      end
      if (stateReg == sch_pkg::SCH_DONE && suspReg && !pendStartReg) begin
        suspReg   <= 1'b0;
        resumeReg <= resumeOkReg && enableReg;
      end
      if (startReg || resumeReg) routineOnReg <= 1'b1;
      if (goOffline) begin
        kindReg <= snumReg[1:0];
        suspReg <= 1'b0;
        if (snumReg != `SN_OFFLINE) stestReg <= {`STEST_RUN, 4'h0};
      end
      if (goCaptive) stestReg <= {`STEST_RUN, 4'h0};
      if (stestDone) stestReg <= {mediaFail ? `STEST_FAIL : `STEST_PASS, 4'h0};
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign busRdata      = rdDataReg;
  assign intrq         = intrqReg;
  assign nvWrite       = nvWriteReg;
  assign nvEnable      = enableReg;
  assign nvAutosave    = autosaveReg;
  assign nvAutoOff     = autoOffReg;
  assign monitorEn     = enableReg && !nvLoadReg;
  assign mediaReq      = stateReg == sch_pkg::SCH_MEDIA;
  assign mediaOp       = opReg;
  assign mediaLogAddr  = snumReg;
  assign routineStart  = startReg;
  assign routineResume = resumeReg;
  assign routineHalt   = haltReg;
  assign routineKind   = kindReg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  chk_captive_busy: assert property (
    goCaptive |=> mediaReq && mediaOp == sch_pkg::SCH_OP_SELFTEST && statusByte[`BIT_BSY])
    else $error("captive self-test without BSY");
  chk_fail_sig: assert property (
    stestDone && mediaFail |=> cylLoReg == `FAIL_LO && cylHiReg == `FAIL_HI
      && errStReg && abrtReg)
    else $error("captive failure signature wrong");
  chk_health_sig: assert property (
    checkDone && !mediaFail |=> cylLoReg == `KEY_LO && cylHiReg == `KEY_HI)
    else $error("healthy return status wrong");
  chk_bsy_then_intrq: assert property (
    ce && stateReg == sch_pkg::SCH_DONE |=> !statusByte[`BIT_BSY] && intrq)
    else $error("completion order wrong");
  chk_offline_ready: assert property (
    routineStart |-> !statusByte[`BIT_BSY] && statusByte[`BIT_RDY] && $past(idle))
    else $error("routine started before completion");
  chk_halt_prompt: assert property (
    cmdWr && routineOnReg |=> routineHalt)
    else $error("routine not halted");
  chk_disabled_abort: assert property (
    cmdWr && !enableReg && !nvLoadReg && featReg != `SUB_ENABLE |=>
      errStReg && abrtReg ##1 intrq)
    else $error("disabled subcommand not aborted");
  chk_log_ro: assert property (
    cmdWr && featReg == `SUB_WRLOG && !hostLog(snumReg) |=> abrtReg && !drqReg)
    else $error("read-only log write accepted");
  chk_log_ext: assert property (
    cmdWr && featReg == `SUB_RDLOG && extLog |=> abrtReg && !mediaReq)
    else $error("extended log read accepted");
  chk_enable_again: assert property (
    goCmd && featReg == `SUB_ENABLE && enableReg |=> !mediaReq && !nvWrite)
    else $error("repeated enable touched attributes");

endmodule // sch_smart_command_handler

// ===== hdl/sch_defs.svh
`ifndef SCH_DEFS_SVH
`define SCH_DEFS_SVH
`define RA_FEAT        4'h0
`define RA_SCNT        4'h1
`define RA_SNUM        4'h2
`define RA_CYLO        4'h3
`define RA_CYHI        4'h4
`define RA_CMD         4'h5
`define RA_ERR         4'h6
`define RA_DATA        4'h7
`define RA_STATE       4'h8
`define RA_MODE        4'h9
`define CMD_SMART      8'hb0
`define KEY_LO         8'h4f
`define KEY_HI         8'hc2
`define FAIL_LO        8'hf4
`define FAIL_HI        8'h2c
`define SUB_RDATTR     8'hd0
`define SUB_RDTHR      8'hd1
`define SUB_AUTOSAVE   8'hd2
`define SUB_SAVE       8'hd3
`define SUB_EXEC       8'hd4
`define SUB_RDLOG      8'hd5
`define SUB_WRLOG      8'hd6
`define SUB_GAP        8'hd7
`define SUB_ENABLE     8'hd8
`define SUB_DISABLE    8'hd9
`define SUB_STATUS     8'hda
`define SUB_AUTOOFF    8'hdb
`define SC_OFF         8'h00
`define SC_ONE         8'h01
`define SC_AUTOSAVE_ON 8'hf1
`define SC_AUTOOFF_ON  8'hf8
`define SN_OFFLINE     8'h00
`define SN_EXT_OFF     8'h02
`define SN_ABORT       8'h7f
`define SN_SHORT_CAP   8'h81
`define SN_EXT_CAP     8'h82
`define LOG_XERR       8'h03
`define LOG_XSTEST     8'h07
`define LOG_HOST_LO    8'h80
`define LOG_HOST_HI    8'h9f
`define BIT_BSY        7
`define BIT_RDY        6
`define BIT_DRQ        3
`define BIT_ERR        0
`define BIT_ABRT       2
`define SECTOR_LAST    9'h1ff
`define STEST_PASS     4'h0
`define STEST_FAIL     4'h4
`define STEST_RUN      4'hf
`define HALT_LIMIT_MS  2000
`define CLK_KHZ        20000
`endif

// ===== hdl/sch_pkg.sv
package sch_pkg;
  typedef enum logic [2:0] {SCH_IDLE, SCH_MEDIA, SCH_XOUT, SCH_XIN, SCH_DONE} sch_state_t;
  typedef enum logic [2:0] {
    SCH_OP_SAVE, SCH_OP_LOAD_ATTR, SCH_OP_LOAD_THR, SCH_OP_SELFTEST,
    SCH_OP_LOAD_LOG, SCH_OP_STORE_LOG, SCH_OP_CHECK
  } sch_op_t;
endpackage

// ===== bench/sch_media_model.sv
`timescale 1ns/1ns
module sch_media_model (
  input  wire logic clk_sys,
  input  wire logic mediaReq,
  input  wire logic failMode,
  output logic      mediaDone,
  output logic      mediaFail
);
  // ----------------------------------------
  // Media engine stand-in
  // ----------------------------------------
  logic [2:0] waitCnt;
  // A fixed wait of a few cycles keeps the handler in its busy state long enough to be seen.
  always_ff @(posedge clk_sys) begin
    waitCnt   <= (mediaReq && !mediaDone) ? waitCnt + 3'h1 : 3'h0;
    mediaDone <= mediaReq && !mediaDone && waitCnt == 3'h3;
    mediaFail <= failMode && mediaReq && waitCnt == 3'h3;
  end
endmodule // sch_media_model

// ===== bench/sch_smart_command_handler_bench.sv
`timescale 1ns/1ns
module sch_smart_command_handler_bench;
  // ----------------------------------------
  // Stimulus and checks
  // ----------------------------------------
  logic       clk_sys  = 1'b0;
  logic       rst_b    = 1'b0;
  logic [3:0] busAddr  = 4'h0;
  logic [7:0] busWdata = 8'h00;
  logic       busWr    = 1'b0;
  logic       busRd    = 1'b0;
  logic       failMode = 1'b0;
  logic       nvIn     = 1'b0;
  logic       rDone    = 1'b0;
  logic [7:0] busRdata, v;
  logic       intrq, nvEnable, nvAutosave, mediaReq, mediaDone, mediaFail, rStart, rHalt;
  int         n_fail      = 0;
  int         checks_done = 0;
  int         nStart      = 0;
  int         nHalt       = 0;
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    nStart += int'(rStart === 1'b1);
    nHalt  += int'(rHalt === 1'b1);
  end
  sch_smart_command_handler #(.HALT_LIMIT_CYC(16)) u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .ce(1'b1), .busAddr(busAddr), .busWdata(busWdata),
    .busWr(busWr), .busRd(busRd), .busRdata(busRdata), .intrq(intrq), .nvEnableIn(nvIn),
    .nvAutosaveIn(nvIn), .nvAutoOffIn(nvIn), .nvWrite(), .nvEnable(nvEnable),
    .nvAutosave(nvAutosave), .nvAutoOff(), .monitorEn(), .mediaReq(mediaReq), .mediaOp(),
    .mediaLogAddr(), .mediaDone(mediaDone), .mediaFail(mediaFail), .bufWe(1'b0),
    .bufAddr(9'h000), .bufWdata(8'h00), .bufRdata(), .routineStart(rStart),
    .routineResume(), .routineHalt(rHalt), .routineKind(), .routineDone(rDone));
  sch_media_model u_media (.clk_sys(clk_sys), .mediaReq(mediaReq), .failMode(failMode),
    .mediaDone(mediaDone), .mediaFail(mediaFail));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // The write strobe is left up between wr calls so that no signal is assigned twice in one step.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    busAddr  <= a;
    busWdata <= d;
    busWr    <= 1'b1;
    busRd    <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    busAddr <= a;
    busRd   <= 1'b1;
    busWr   <= 1'b0;
    @(posedge clk_sys);
    busRd <= 1'b0;
    #1 d = busRdata;
    @(posedge clk_sys);
  endtask
  task automatic issue(input logic [7:0] f, input logic [7:0] s, input logic [7:0] n);
    wr(4'h0, f);
    wr(4'h1, s);
    wr(4'h2, n);
    wr(4'h3, 8'h4f);
    wr(4'h4, 8'hc2);
    wr(4'h5, 8'hb0);
    busWr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic fin(input logic [7:0] e);
    for (int i = 0; i < 80 && intrq !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    rd(4'h5, v);
    chk(v, e);
  endtask
  task automatic drain(input bit cmp);
    v = 8'h00;
    for (int i = 0; i < 40 && v[3] !== 1'b1; i++) rd(4'h5, v);
    chk(v, 8'h48);
    for (int i = 0; i < 512; i++) begin
      rd(4'h7, v);
      if (cmp) chk(v, 8'(i));
    end
    fin(8'h40);
  endtask
  task automatic run(input logic [7:0] f, input logic [7:0] s, input logic [7:0] n,
                     input logic [7:0] e);
    issue(f, s, n);
    fin(e);
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    run(8'hd3, 8'h00, 8'h00, 8'h41);
    run(8'hd8, 8'h00, 8'h00, 8'h40);
    chk(nvEnable, 1'b1);
    run(8'hd8, 8'h00, 8'h00, 8'h40);
    run(8'hd2, 8'hf1, 8'h00, 8'h40);
    run(8'hd2, 8'h33, 8'h00, 8'h41);
    chk(nvAutosave, 1'b1);
    run(8'hdb, 8'hf8, 8'h00, 8'h40);
    run(8'hdb, 8'h55, 8'h00, 8'h41);
    rd(4'h9, v);
    chk(v, 8'h38);
    run(8'hd3, 8'h00, 8'h00, 8'h40);
    run(8'hd7, 8'h00, 8'h00, 8'h41);
    run(8'hd5, 8'h01, 8'h03, 8'h41);
    run(8'hd6, 8'h01, 8'h06, 8'h41);
    run(8'hd6, 8'h01, 8'h00, 8'h41);
    run(8'hd4, 8'h00, 8'h00, 8'h40);
    chk(8'(nStart), 8'h01);
    failMode <= 1'b1;
    run(8'hda, 8'h00, 8'h00, 8'h40);
    chk(8'(nHalt), 8'h01);
    rd(4'h3, v);
    chk(v, 8'hf4);
    run(8'hd4, 8'h00, 8'h81, 8'h41);
    rd(4'h4, v);
    chk(v, 8'h2c);
    rd(4'h6, v);
    chk(v, 8'h04);
    failMode <= 1'b0;
    run(8'hda, 8'h00, 8'h00, 8'h40);
    rd(4'h4, v);
    chk(v, 8'hc2);
    issue(8'hd0, 8'h00, 8'h00);
    drain(1'b0);
    issue(8'hd6, 8'h01, 8'h80);
    for (int i = 0; i < 512; i++) wr(4'h7, 8'(i));
    busWr <= 1'b0;
    fin(8'h40);
    issue(8'hd5, 8'h01, 8'h80);
    drain(1'b1);
    run(8'hd4, 8'h00, 8'h01, 8'h40);
    rd(4'h8, v);
    chk(v, 8'hf0);
    rDone <= 1'b1;
    @(posedge clk_sys);
    rDone <= 1'b0;
    rd(4'h8, v);
    chk(v, 8'h00);
    run(8'hd9, 8'h00, 8'h00, 8'h40);
    chk(nvAutosave, 1'b0);
    run(8'hd9, 8'h00, 8'h00, 8'h41);
    nvIn  <= 1'b1;
    rst_b <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(nvEnable, 1'b1);
    chk(nvAutosave, 1'b1);
    run(8'hd8, 8'h00, 8'h00, 8'h40);
    report_and_stop();
  end
  initial begin
    #500000;
    n_fail++;
    report_and_stop();
  end
endmodule // sch_smart_command_handler_bench
